// ---- src/sra_pkg.sv ----
// Shared constants for the serial register access port and its host controller
package sra_pkg;
   // Instruction word layout
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS  = 8;
   localparam int ADDR_W     = 13;
   localparam int I_RW       = 15;
   localparam int I_CNT_HI   = 14;
   localparam int I_CNT_LO   = 13;
   // Byte count codes
   localparam logic [1:0] CNT_STREAM = 2'h3;
   // Bit counter end points
   localparam logic [3:0] BIT_LAST_INSTR = 4'hf;
   localparam logic [3:0] BIT_LAST_BYTE  = 4'h7;
   // Port control addresses and bit positions
   localparam logic [ADDR_W-1:0] A_CFG   = 13'h0000;
   localparam logic [ADDR_W-1:0] A_RBSEL = 13'h0004;
   localparam logic [ADDR_W-1:0] A_UPD   = 13'h0005;
   localparam int CFG_LSB_BIT = 6;
   localparam int CFG_4W_BIT  = 7;
   localparam int RBSEL_BIT   = 0;
   localparam int UPD_BIT     = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Host Avalon word indexes
   localparam logic [2:0] H_CMD   = 3'h0;
   localparam logic [2:0] H_WDATA = 3'h1;
   localparam logic [2:0] H_CTRL  = 3'h2;
   localparam logic [2:0] H_STAT  = 3'h3;
   localparam logic [2:0] H_RDATA = 3'h4;
   localparam int CMD_RW_BIT  = 31;
   localparam int CMD_CNT_HI  = 30;
   localparam int CMD_CNT_LO  = 29;
   localparam int CTRL_LSB    = 0;
   localparam int CTRL_4W     = 1;
   // Serial clock timing made by the host
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int SCLK_HALF_NS      = 80;
   localparam int SCLK_HALF_CYC     = (SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
endpackage

// ---- src/sra_if.sv ----
// Serial link between the register access port and its host
`timescale 1ns/1ps
interface sra_if;
   logic cs_n;          // Chip select, active low
   logic sclk;          // Serial clock from host
   logic sdio_dev_o;    // Device drive of shared data pin
   logic sdio_dev_oe;   // Device enable on shared data pin
   logic sdio_host_o;   // Host drive of shared data pin
   logic sdio_host_oe;  // Host enable on shared data pin
   logic sdo_o;         // Device drive of output pin
   logic sdo_oe;        // Device enable of output pin
   logic sdio;          // Resolved shared data level
   logic sdo;           // Resolved output pin level
   // Released wires float high through the pull-up
   assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);
   assign sdo  = sdo_oe ? sdo_o : 1'b1;
   modport dev (input cs_n, input sclk, input sdio, output sdio_dev_o, output sdio_dev_oe,
                output sdo_o, output sdo_oe);
   modport host (input sdio, input sdo, output cs_n, output sclk, output sdio_host_o,
                 output sdio_host_oe);
endinterface

// ---- src/sra_dev.sv ----
// Device end: serial register access port with buffered and active registers
// Notes on behaviour
// R01: Sixteen-bit instruction precedes payload bytes
// R02: Instruction: direction, count high, low, address
// R03: Count 00/01/10 = 1/2/3 bytes, 11 streams
// R04: Write bits captured on rising serial clock
// R05: Byte-boundary deselect stalls; final byte ends cycle
// R06: Deselect inside a byte aborts to idle
// R07: Address steps through every location, none skipped
// R08: Update bit copies buffer to active, self-clears
// R09: External pin also triggers the update
// R10: Read shifts out N bytes after instruction
// R11: Read data changes on falling clock edges
// R12: Readback source chosen by select bit
// R13: Only long thirteen-bit address instruction
// R14: LSB-first bit switches order from next operation
// R15: MSB-first mode decrements the address
// R16: LSB-first mode increments the address
// R17: Host tolerates zero hold on last bit
// R18: Host writes defaults into reserved locations
// R19: Short select pulse returns port to idle; a pulse with no clock edges leaves the port waiting in ST_INSTR
// R20: Deselected port releases both data pins
// R21: Three-wire mode after reset
// R22: Host deselects after last streamed byte
// R23: Each written byte stored before address steps
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module sra_dev
   import sra_pkg::*;
#(
   parameter int REG_DEPTH = 16  // Implemented byte registers from address zero
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   sra_if.dev                     link,
   input  wire logic              upd_pin,
   input  wire logic [ADDR_W-1:0] user_addr,
   output logic      [7:0]        user_data,
   output logic                   lsb_first,
   output logic                   four_wire
);
   localparam int IDX_W = $clog2(REG_DEPTH);

   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} sra_state_e;

   // Synchronisers for pins and the update input
   logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
   logic cs_s1_reg, cs_s2_reg;
   logic din_s1_reg, din_s2_reg;
   logic upd_s1_reg, upd_s2_reg, upd_d_reg;

   // Transfer state
   sra_state_e        state_reg, state_next;     // Control state
   logic [15:0]       sh_reg, sh_next;           // Receive shifter
   logic [3:0]        bit_reg, bit_next;         // Bit within field
   logic [ADDR_W-1:0] addr_reg, addr_next;       // Address generator
   logic              rw_reg, rw_next;           // High for read
   logic [1:0]        cnt_reg, cnt_next;         // Byte count code
   logic [1:0]        nb_reg, nb_next;           // Bytes done so far
   logic              op_lsb_reg, op_lsb_next;   // Order for this operation
   logic              op_4w_reg, op_4w_next;     // Pin use for this operation
   logic [7:0]        tx_reg, tx_next;           // Read byte being sent
   logic              out_reg, out_next;         // Read data bit
   logic              dio_oe_reg, dio_oe_next;   // Shared pin enable
   logic              sdo_oe_reg, sdo_oe_next;   // Output pin enable

   // Port control registers and register storage
   logic [7:0] cfg_reg, cfg_next;              // Order and wire mode
   logic       rbsel_reg, rbsel_next;          // High reads active set
   logic [7:0] buf_reg [REG_DEPTH];            // Buffer registers
   logic [7:0] buf_next [REG_DEPTH];
   logic [7:0] act_reg [REG_DEPTH];            // Active registers
   logic [7:0] act_next [REG_DEPTH];
   logic [7:0] udata_next;

   // Per-cycle helpers
   logic              rise, fall;
   logic [15:0]       sh_in;
   logic [7:0]        rx_byte;
   logic [ADDR_W-1:0] step_addr;
   logic [ADDR_W-1:0] instr_addr;
   logic              wr_en;
   logic              do_upd;

   // Byte seen by a read at a given address
   function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == A_CFG) begin
         v = cfg_reg;
      end else if (a == A_RBSEL) begin
         v = {7'h00, rbsel_reg};
      end else if (a == A_UPD) begin
         v = 8'h00;                                // Update bit always reads clear [R08]
      end else if (a < ADDR_W'(REG_DEPTH)) begin
         v = rbsel_reg ? act_reg[a[IDX_W-1:0]] : buf_reg[a[IDX_W-1:0]];  // [R12]
      end
      return v;
   endfunction

   // Edge finding on the second synchroniser stage only
   always_comb begin
      rise       = sclk_s2_reg & ~sclk_d_reg;      // [R04]
      fall       = ~sclk_s2_reg & sclk_d_reg;      // [R11]
      sh_in      = op_lsb_reg ? {din_s2_reg, sh_reg[15:1]} : {sh_reg[14:0], din_s2_reg};  // [R14]
      rx_byte    = op_lsb_reg ? sh_in[15:8] : sh_in[7:0];
      step_addr  = op_lsb_reg ? addr_reg + 13'h0001 : addr_reg - 13'h0001;  // [R15] [R16] [R07]
      instr_addr = sh_in[ADDR_W-1:0];              // Long format only [R13]
      do_upd     = upd_s2_reg & ~upd_d_reg;        // [R09]
   end

   // Transfer control: framing, shifting, addressing and read drive
   always_comb begin
      state_next  = state_reg;
      sh_next     = sh_reg;
      bit_next    = bit_reg;
      addr_next   = addr_reg;
      rw_next     = rw_reg;
      cnt_next    = cnt_reg;
      nb_next     = nb_reg;
      op_lsb_next = op_lsb_reg;
      op_4w_next  = op_4w_reg;
      tx_next     = tx_reg;
      out_next    = out_reg;
      dio_oe_next = dio_oe_reg;
      sdo_oe_next = sdo_oe_reg;
      cfg_next    = cfg_reg;
      rbsel_next  = rbsel_reg;
      wr_en       = 1'b0;
      if (cs_s2_reg) begin
         // Deselected: pins released at once [R20]
         dio_oe_next = 1'b0;
         sdo_oe_next = 1'b0;
         if (state_reg == ST_DONE) begin
            state_next = ST_IDLE;                  // Final byte already ended the cycle [R05]
         end else if (state_reg != ST_IDLE && (bit_reg[2:0] != 3'h0 || cnt_reg == CNT_STREAM)) begin
            state_next = ST_IDLE;                  // Mid-byte or stream end [R06] [R19] [R22]
         end
         // Byte boundary outside streaming keeps state: a stall [R05]
      end else if (state_reg == ST_IDLE) begin
         // New operation latches order and pin mode [R14] [R21]
         state_next  = ST_INSTR;
         bit_next    = 4'h0;
         nb_next     = 2'h0;
         cnt_next    = 2'h0;
         op_lsb_next = cfg_reg[CFG_LSB_BIT];
         op_4w_next  = cfg_reg[CFG_4W_BIT];
      end else if (rise && state_reg == ST_INSTR) begin
         sh_next  = sh_in;
         bit_next = bit_reg + 4'h1;
         if (bit_reg == BIT_LAST_INSTR) begin
            // Instruction complete [R01] [R02] [R03]
            rw_next    = sh_in[I_RW];
            cnt_next   = {sh_in[I_CNT_HI], sh_in[I_CNT_LO]};
            addr_next  = instr_addr;
            bit_next   = 4'h0;
            state_next = ST_DATA;
            tx_next    = rd_byte(instr_addr);      // First read byte [R10]
         end
      end else if (rise && state_reg == ST_DATA) begin
         sh_next  = sh_in;
         bit_next = bit_reg + 4'h1;
         if (bit_reg == BIT_LAST_BYTE) begin
            bit_next  = 4'h0;
            wr_en     = ~rw_reg;                   // Store before stepping [R23] [R04]
            addr_next = step_addr;                 // [R07]
            nb_next   = nb_reg + 2'h1;
            tx_next   = rd_byte(step_addr);        // Next read byte [R10]
            if (cnt_reg != CNT_STREAM && nb_reg == cnt_reg) begin
               state_next = ST_DONE;               // Last counted byte [R03] [R05]
            end
            if (~rw_reg && addr_reg == A_CFG) begin
               cfg_next = rx_byte;                 // Used from the next operation [R14]
            end
            if (~rw_reg && addr_reg == A_RBSEL) begin
               rbsel_next = rx_byte[RBSEL_BIT];    // [R12]
            end
         end
      end else if (fall && state_reg == ST_DATA && rw_reg) begin
         // Read bit changes on the falling edge [R11]
         out_next    = op_lsb_reg ? tx_reg[0] : tx_reg[7];
         tx_next     = op_lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
         dio_oe_next = ~op_4w_reg;                 // [R21]
         sdo_oe_next = op_4w_reg;
      end
   end

   // Buffer writes and buffer-to-active update, one entry per loop pass
   always_comb begin
      for (int i = 0; i < REG_DEPTH; i++) begin
         buf_next[i] = buf_reg[i];
         if (wr_en && addr_reg == ADDR_W'(i) && addr_reg != A_CFG && addr_reg != A_RBSEL
             && addr_reg != A_UPD) begin
            buf_next[i] = rx_byte;                 // [R04] [R23]
         end
         act_next[i] = act_reg[i];
         if (do_upd || (wr_en && addr_reg == A_UPD && rx_byte[UPD_BIT])) begin
            act_next[i] = buf_reg[i];              // Update pulse, never stored [R08] [R09]
         end
      end
      udata_next = 8'h00;
      if (user_addr < ADDR_W'(REG_DEPTH)) begin
         udata_next = act_reg[user_addr[IDX_W-1:0]];
      end
   end

   // Synchronisers: first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         cs_s1_reg   <= 1'b1;
         cs_s2_reg   <= 1'b1;
         din_s1_reg  <= 1'b0;
         din_s2_reg  <= 1'b0;
         upd_s1_reg  <= 1'b0;
         upd_s2_reg  <= 1'b0;
         upd_d_reg   <= 1'b0;
      end else begin
         sclk_s1_reg <= link.sclk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg  <= sclk_s2_reg;
         cs_s1_reg   <= link.cs_n;
         cs_s2_reg   <= cs_s1_reg;
         din_s1_reg  <= link.sdio;
         din_s2_reg  <= din_s1_reg;
         upd_s1_reg  <= upd_pin;
         upd_s2_reg  <= upd_s1_reg;
         upd_d_reg   <= upd_s2_reg;
      end
   end

   // Transfer and control registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= ST_IDLE;
         sh_reg     <= 16'h0000;
         bit_reg    <= 4'h0;
         addr_reg   <= 13'h0000;
         rw_reg     <= 1'b0;
         cnt_reg    <= 2'h0;
         nb_reg     <= 2'h0;
         op_lsb_reg <= 1'b0;
         op_4w_reg  <= 1'b0;
         tx_reg     <= 8'h00;
         out_reg    <= 1'b0;
         dio_oe_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
         cfg_reg    <= CFG_RESET;                  // MSB first, three-wire [R14] [R21]
         rbsel_reg  <= 1'b0;
         user_data  <= 8'h00;
      end else begin
         state_reg  <= state_next;
         sh_reg     <= sh_next;
         bit_reg    <= bit_next;
         addr_reg   <= addr_next;
         rw_reg     <= rw_next;
         cnt_reg    <= cnt_next;
         nb_reg     <= nb_next;
         op_lsb_reg <= op_lsb_next;
         op_4w_reg  <= op_4w_next;
         tx_reg     <= tx_next;
         out_reg    <= out_next;
         dio_oe_reg <= dio_oe_next;
         sdo_oe_reg <= sdo_oe_next;
         cfg_reg    <= cfg_next;
         rbsel_reg  <= rbsel_next;
         user_data  <= udata_next;
      end
   end

   // Register storage has no reset value other than zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < REG_DEPTH; i++) begin
            buf_reg[i] <= 8'h00;
            act_reg[i] <= 8'h00;
         end
      end else begin
         buf_reg <= buf_next;
         act_reg <= act_next;
      end
   end

   // Mode outputs mirror the config register flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lsb_first <= 1'b0;
         four_wire <= 1'b0;
      end else begin
         lsb_first <= cfg_next[CFG_LSB_BIT];
         four_wire <= cfg_next[CFG_4W_BIT];
      end
   end

   // Pins come straight from flops
   assign link.sdio_dev_o  = out_reg;
   assign link.sdio_dev_oe = dio_oe_reg;
   assign link.sdo_o       = out_reg;
   assign link.sdo_oe      = sdo_oe_reg;
endmodule

// ---- src/sra_host.sv ----
// Host end: serial master with Avalon-MM command registers
`timescale 1ns/1ps
module sra_host
   import sra_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC  // System clocks per serial clock half
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   sra_if.host              link,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);
   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} sra_hstate_e;

   sra_hstate_e st_reg, st_next;          // Serial sequencer
   logic [7:0]  hc_reg, hc_next;          // Half period counter
   logic [5:0]  idx_reg, idx_next;        // Bit index in frame
   logic [5:0]  nbits_reg, nbits_next;    // Frame length in bits
   logic [39:0] frame_reg, frame_next;    // Bits in send order
   logic        rd_reg, rd_next;          // Read operation
   logic        lsb_reg, lsb_next;        // Order setting of device
   logic        w4_reg, w4_next;          // Device uses output pin
   logic [23:0] wdata_reg, wdata_next;    // Payload to write
   logic [23:0] rdata_reg, rdata_next;    // Payload read back
   logic        cs_reg, cs_next;
   logic        sclk_reg, sclk_next;
   logic        mo_reg, mo_next;
   logic        moe_reg, moe_next;
   logic        wr_reg, wr_next;          // Waitrequest
   logic [31:0] rdd_reg, rdd_next;        // Read data to bus
   logic        mi_s1_reg, mi_s2_reg;     // Returned data synchroniser
   logic [15:0] instr;
   logic [1:0]  cnt;
   logic [5:0]  pidx;
   logic [4:0]  rpos;

   function automatic logic [7:0] ord8(input logic [7:0] x, input logic lsb);
      return lsb ? {<<{x}} : x;
   endfunction

   // Command decode, Avalon answer and serial sequencing
   always_comb begin
      st_next    = st_reg;
      hc_next    = hc_reg;
      idx_next   = idx_reg;
      nbits_next = nbits_reg;
      frame_next = frame_reg;
      rd_next    = rd_reg;
      lsb_next   = lsb_reg;
      w4_next    = w4_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      cs_next    = cs_reg;
      sclk_next  = sclk_reg;
      mo_next    = mo_reg;
      moe_next   = moe_reg;
      rdd_next   = rdd_reg;
      cnt        = avs_writedata[CMD_CNT_HI:CMD_CNT_LO];
      instr      = {avs_writedata[CMD_RW_BIT], cnt, avs_writedata[ADDR_W-1:0]};  // [R02]
      pidx       = idx_reg - 6'(INSTR_BITS);
      rpos       = {pidx[4:3], lsb_reg ? pidx[2:0] : 3'h7 - pidx[2:0]};
      // One wait cycle, then a single low cycle takes the request
      wr_next    = ~((avs_read | avs_write) & wr_reg);
      if (avs_read && wr_reg) begin
         if (avs_address == H_CTRL) begin
            rdd_next = {30'h0, w4_reg, lsb_reg};
         end else if (avs_address == H_STAT) begin
            rdd_next = {31'h0, st_reg != HS_IDLE};
         end else if (avs_address == H_RDATA) begin
            rdd_next = {8'h00, rdata_reg};
         end else if (avs_address == H_WDATA) begin
            rdd_next = {8'h00, wdata_reg};
         end else begin
            rdd_next = 32'h0;
         end
      end
      if (avs_write && !wr_reg) begin
         if (avs_address == H_WDATA) begin
            wdata_next = avs_writedata[23:0];
         end else if (avs_address == H_CTRL && st_reg == HS_IDLE) begin
            lsb_next = avs_writedata[CTRL_LSB];
            w4_next  = avs_writedata[CTRL_4W];
         end
      end
      case (st_reg)
         HS_IDLE: begin
            if (avs_write && !wr_reg && avs_address == H_CMD) begin
               // Streaming sends three bytes then deselects [R03] [R22]
               rd_next    = avs_writedata[CMD_RW_BIT];
               nbits_next = 6'(INSTR_BITS) + ((cnt == CNT_STREAM) ? 6'd24 : {1'b0, cnt + 2'h1, 3'h0});
               frame_next = {lsb_reg ? {<<{instr}} : instr, ord8(wdata_reg[7:0], lsb_reg),
                             ord8(wdata_reg[15:8], lsb_reg), ord8(wdata_reg[23:16], lsb_reg)};  // [R14]
               mo_next    = lsb_reg ? instr[0] : instr[15];
               moe_next   = 1'b1;
               cs_next    = 1'b0;
               idx_next   = 6'h00;
               hc_next    = 8'h00;
               st_next    = HS_LOW;
            end
         end
         HS_LOW: begin
            hc_next = hc_reg + 8'h01;
            if (hc_reg == 8'(HALF_CYC - 1)) begin
               hc_next   = 8'h00;
               sclk_next = 1'b1;                   // Device samples here [R01]
               st_next   = HS_HIGH;
            end
         end
         HS_HIGH: begin
            hc_next = hc_reg + 8'h01;
            if (hc_reg == 8'(HALF_CYC - 1)) begin
               hc_next   = 8'h00;
               sclk_next = 1'b0;
               if (rd_reg && idx_reg >= 6'(INSTR_BITS)) begin
                  rdata_next[rpos] = mi_s2_reg;    // Sampled at the falling edge [R17]
               end
               if (idx_reg == nbits_reg - 6'h01) begin
                  st_next = HS_END;
               end else begin
                  idx_next = idx_reg + 6'h01;
                  mo_next  = frame_reg[6'd38 - idx_reg];
                  moe_next = ~(rd_reg && idx_reg >= 6'(INSTR_BITS - 1));
                  st_next  = HS_LOW;
               end
            end
         end
         default: begin
            hc_next = hc_reg + 8'h01;
            if (hc_reg == 8'(HALF_CYC - 1)) begin
               cs_next  = 1'b1;
               moe_next = 1'b0;
               st_next  = HS_IDLE;
            end
         end
      endcase
   end

   // Registers; returned data passes two flops first
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg    <= HS_IDLE;
         hc_reg    <= 8'h00;
         idx_reg   <= 6'h00;
         nbits_reg <= 6'h00;
         frame_reg <= 40'h0;
         rd_reg    <= 1'b0;
         lsb_reg   <= 1'b0;
         w4_reg    <= 1'b0;
         wdata_reg <= 24'h0;
         rdata_reg <= 24'h0;
         cs_reg    <= 1'b1;
         sclk_reg  <= 1'b0;
         mo_reg    <= 1'b0;
         moe_reg   <= 1'b0;
         wr_reg    <= 1'b1;
         rdd_reg   <= 32'h0;
         mi_s1_reg <= 1'b0;
         mi_s2_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         hc_reg    <= hc_next;
         idx_reg   <= idx_next;
         nbits_reg <= nbits_next;
         frame_reg <= frame_next;
         rd_reg    <= rd_next;
         lsb_reg   <= lsb_next;
         w4_reg    <= w4_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         cs_reg    <= cs_next;
         sclk_reg  <= sclk_next;
         mo_reg    <= mo_next;
         moe_reg   <= moe_next;
         wr_reg    <= wr_next;
         rdd_reg   <= rdd_next;
         mi_s1_reg <= w4_reg ? link.sdo : link.sdio;
         mi_s2_reg <= mi_s1_reg;
      end
   end

   assign link.cs_n         = cs_reg;
   assign link.sclk         = sclk_reg;
   assign link.sdio_host_o  = mo_reg;
   assign link.sdio_host_oe = moe_reg;
   assign avs_readdata      = rdd_reg;
   assign avs_waitrequest   = wr_reg;
endmodule

// ---- testbench/sra_asserts.sv ----
// Link checks between the host end and the register port end
`timescale 1ns/1ps
module sra_asserts (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe,
   input wire logic sdio_host_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   chk_pins_released: assert property (cs_n [*4] |-> !sdio_dev_oe && !sdo_oe)
      else $error("pin driven while deselected");
   chk_no_clash: assert property (!(sdio_dev_oe && sdio_host_oe))
      else $error("both ends drive data pin");
   chk_one_pin: assert property (!(sdio_dev_oe && sdo_oe))
      else $error("both output pins enabled");
   chk_sdo_mirror: assert property (sdo_oe |-> sdo_o == sdio_dev_o)
      else $error("output pins disagree");
   chk_fall_change: assert property ($changed(sdio_dev_o) && $past(sdio_dev_oe | sdo_oe) |-> !sclk)
      else $error("read bit moved while clock high");
   chk_clk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("clock high phase wrong");
   chk_cs_setup: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
      else $error("first clock edge misplaced");
   chk_idle_clock: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("clock runs while deselected");
   cover property ($rose(sdio_dev_oe));
   cover property ($rose(sdo_oe));
   cover property ($fell(cs_n));
endmodule

// ---- testbench/spi_register_access_port_tb.sv ----
// Bench: host and port face each other, reference model of buffer and active sets
`timescale 1ns/1ps
module spi_register_access_port_tb;
   import sra_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, upd_pin = 1'b0, avs_read = 1'b0, avs_write = 1'b0, lsb = 1'b0, rbs = 1'b0;
   logic [2:0] avs_address = 3'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'had5218f4;
   logic avs_waitrequest, lsb_first, four_wire;
   logic [ADDR_W-1:0] user_addr = 13'h0;
   logic [7:0] user_data;
   logic [7:0] act [16] = '{default: 8'h0};  // Model of active set
   logic [7:0] buff [16] = '{default: 8'h0}; // Model of buffer set
   int n_errors = 0, tests_run = 0;
   sra_if link ();
   sra_dev u_sra_dev (.sys_clk(sys_clk), .rstn(rstn), .link(link), .upd_pin(upd_pin), .user_addr(user_addr),
      .user_data(user_data), .lsb_first(lsb_first), .four_wire(four_wire));
   sra_host u_sra_host (.sys_clk(sys_clk), .rstn(rstn), .link(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   sra_asserts u_sra_asserts (.sys_clk(sys_clk), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
      .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe(link.sdio_dev_oe), .sdio_host_oe(link.sdio_host_oe),
      .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));
   always #10 sys_clk = ~sys_clk;
   function automatic logic [31:0] nx();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One Avalon cycle, held until waitrequest is seen low
   task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Serial transfer through the host, model updated or compared per byte
   task automatic op(input logic r, input logic [1:0] c, input logic [12:0] a, input logic [31:0] d);
      logic [12:0] x;
      if (!r) av(1'b1, H_WDATA, d);
      av(1'b1, H_CMD, {r, c, 16'h0, a});
      do av(1'b0, H_STAT, 32'h0); while (rd[0] !== 1'b0);
      if (r) av(1'b0, H_RDATA, 32'h0);
      for (int i = 0; i < ((c == 2'h3) ? 3 : c + 1); i++) begin
         x = lsb ? a + 13'(i) : a - 13'(i);
         if (r) cmp(32'(rd[8*i+:8]), 32'(rbs ? act[x[3:0]] : buff[x[3:0]]));
         else if (x > 13'h5 && x < 13'h10) buff[x[3:0]] = d[8*i+:8];
      end
   endtask
   task automatic chk_act();
      for (int i = 6; i < 16; i++) begin
         @(posedge sys_clk);
         user_addr <= 13'(i);
         @(posedge sys_clk);
         @(negedge sys_clk);
         cmp(32'(user_data), 32'(act[i]));
      end
   endtask
   task automatic upd();
      op(1'b0, 2'h0, A_UPD, 32'h1);
      act = buff;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      cmp(32'({lsb_first, four_wire}), 32'h0);
      op(1'b0, 2'h2, 13'h00c, nx());
      op(1'b0, 2'h3, 13'h009, nx());
      chk_act();
      upd();
      chk_act();
      op(1'b1, 2'h2, 13'h00c, 32'h0);
      op(1'b0, 2'h1, 13'h007, nx());
      op(1'b0, 2'h0, 13'h00f, nx());
      op(1'b0, 2'h0, A_RBSEL, 32'h1);
      rbs = 1'b1;
      op(1'b1, 2'h1, 13'h00f, 32'h0);
      upd_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      upd_pin <= 1'b0;
      act = buff;
      chk_act();
      op(1'b0, 2'h0, A_CFG, 32'h40);
      lsb = 1'b1;
      av(1'b1, H_CTRL, 32'h1);
      op(1'b0, 2'h3, 13'h008, nx());
      upd();
      chk_act();
      op(1'b0, 2'h0, A_CFG, 32'hc0);
      av(1'b1, H_CTRL, 32'h3);
      op(1'b1, 2'h3, 13'h006, 32'h0);
      cmp(32'({lsb_first, four_wire}), 32'h3);
      finish_test();
   end
   initial begin
      #1000000;
      n_errors++;
      finish_test();
   end
endmodule
